// >>> core/evr_pkg.sv
`default_nettype none
package evr_pkg;
  localparam int NUM_DST = 46;
  localparam int SRC_W = 190;
  localparam int ADDR_W = 12;
  localparam int PCFG_W = 12;
  localparam logic [7:0] SEL_OFF = 8'h00;
  localparam logic [7:0] SEL_MIN = 8'h01;
  localparam logic [7:0] SEL_MAX = 8'hBD;
  localparam logic [7:0] LINK_RESET = 8'h00;
  localparam logic [7:0] OPT_RESET = 8'h00;
  localparam logic [PCFG_W-1:0] PCFG_RESET = 12'h000;
  // destinations that own a link setting register
  localparam logic [NUM_DST-1:0] DST_IMPL = 46'h207A_1FFD_BC99;
  localparam logic [ADDR_W-1:0] LINK_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] LINK_END = 12'h0B8;
  localparam logic [ADDR_W-1:0] OPT_A_ADDR = 12'h100;
  localparam logic [ADDR_W-1:0] OPT_D_ADDR = 12'h10C;
  localparam logic [ADDR_W-1:0] OPT_F_ADDR = 12'h114;
  localparam logic [ADDR_W-1:0] OPT_H_ADDR = 12'h11C;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h120;
  localparam logic [ADDR_W-1:0] PCFG_B_ADDR = 12'h130;
  localparam logic [ADDR_W-1:0] PCFG_E_ADDR = 12'h134;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h140;
  localparam int CTRL_STOP_BIT = 0;
  localparam int STATUS_STOP_BIT = 16;
  localparam int PCFG_MASK_LSB = 0;
  localparam int PCFG_BIT_LSB = 8;
  localparam int PCFG_GROUP_BIT = 11;
  localparam int OPA_MULTI_TIMER_CHANNEL0_LSB = 0;
  localparam int OPD_BYTE_TIMER_CHANNEL1_LSB = 2;
  localparam int OPD_BYTE_TIMER_CHANNEL3_LSB = 6;
  localparam logic [1:0] OP_START = 2'b00;
  localparam logic [1:0] OP_RESTART = 2'b01;
  localparam logic [1:0] OP_COUNT = 2'b10;
  localparam logic [1:0] OP_NONE = 2'b11;
  localparam int DST_MULTI_TIMER_CHANNEL0 = 4;
  localparam int DST_BYTE_TIMER_CHANNEL1 = 16;
  localparam int DST_BYTE_TIMER_CHANNEL3 = 18;
  localparam int DST_PORT_B = 36;
  localparam int DST_PORT_E = 37;
  localparam int EVT_PORT_B = 188;
  localparam int EVT_PORT_E = 189;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// >>> core/evr_reg_if.sv
`default_nettype none
interface evr_reg_if;
  logic wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_en;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
               input wr_err, rd_data, rd_err);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface
`default_nettype wire

// >>> core/evr_axil_slave.sv
`default_nettype none
module evr_axil_slave (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [11:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [11:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  evr_reg_if.bus reg_bus
);
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic ar_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [11:0] araddr;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } evr_axs_t;

  evr_axs_t s_reg;
  evr_axs_t s_next;

  always_comb begin
    s_next = s_reg;
    if (i_awvalid && s_reg.awready) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = i_awaddr;
    end
    if (i_wvalid && s_reg.wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = i_wdata;
      s_next.wstrb = i_wstrb;
    end
    // write lands once both halves are held, whatever their order
    if (s_reg.aw_got && s_reg.w_got) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = reg_bus.wr_err ? evr_pkg::RESP_SLVERR : evr_pkg::RESP_OKAY;
    end
    if (s_reg.bvalid && i_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (i_arvalid && s_reg.arready) begin
      s_next.ar_got = 1'b1;
      s_next.araddr = i_araddr;
    end
    if (s_reg.ar_got) begin
      s_next.ar_got = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rdata = reg_bus.rd_data;
      s_next.rresp = reg_bus.rd_err ? evr_pkg::RESP_SLVERR : evr_pkg::RESP_OKAY;
    end
    if (s_reg.rvalid && i_rready) begin
      s_next.rvalid = 1'b0;
    end
    // one write and one read in flight at most
    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready = !s_next.w_got && !s_next.bvalid;
    s_next.arready = !s_next.ar_got && !s_next.rvalid;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_bus.wr_en = s_reg.aw_got && s_reg.w_got;
  assign reg_bus.wr_addr = s_reg.awaddr;
  assign reg_bus.wr_data = s_reg.wdata;
  assign reg_bus.wr_strb = s_reg.wstrb;
  assign reg_bus.rd_en = s_reg.ar_got;
  assign reg_bus.rd_addr = s_reg.araddr;
  assign o_awready = s_reg.awready;
  assign o_wready = s_reg.wready;
  assign o_bvalid = s_reg.bvalid;
  assign o_bresp = s_reg.bresp;
  assign o_arready = s_reg.arready;
  assign o_rvalid = s_reg.rvalid;
  assign o_rdata = s_reg.rdata;
  assign o_rresp = s_reg.rresp;
endmodule // evr_axil_slave
`default_nettype wire

// >>> core/evr_port_event.sv
`default_nettype none
module evr_port_event (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_stop,
  input wire logic [11:0] i_cfg,
  input wire logic [7:0] i_pins,
  input wire logic i_dst_evt,
  output logic o_src_evt,
  output logic [7:0] o_out
);
  typedef struct packed {
    logic [7:0] prev;
    logic src_evt;
    logic [7:0] out;
  } evr_port_t;

  evr_port_t s_reg;
  evr_port_t s_next;
  logic [7:0] sel;

  always_comb begin
    s_next = s_reg;
    if (i_cfg[evr_pkg::PCFG_GROUP_BIT]) begin
      sel = i_cfg[evr_pkg::PCFG_MASK_LSB +: 8];
    end else begin
      sel = 8'h01 << i_cfg[evr_pkg::PCFG_BIT_LSB +: 3];
    end
    // keep tracking pins while stopped so a restart sees no stale edge
    s_next.prev = i_pins;
    s_next.src_evt = !i_stop && |(i_pins & ~s_reg.prev & sel);
    if (!i_stop && i_dst_evt) begin
      s_next.out = s_reg.out ^ sel;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_src_evt = s_reg.src_evt;
  assign o_out = s_reg.out;
endmodule // evr_port_event
`default_nettype wire

// >>> core/evr_top.sv
// Summary of operation
// - any of the 189 source events reaches destination modules with no processor involved.
// - a link select field of zero forwards nothing to its destination.
// - a select value from 01h to BDh routes the source event of that number.
// - link setting registers exist only for destinations 0,3,4,7,10-13,15,16,18-28,33,35-38,45.
// - timer destinations act as configured when a routed event arrives.
// - the first multi-function timer channel operation sits in bits 1:0 of option A.
// - byte timers 1 and 3 operations sit in bits 3:2 and 7:6 of option D.
// - only ports B and E take part in event linking.
// - single-port mode ties the link to one configured port bit.
// - port-group mode ties one link to a configured group of the eight port bits.
// - module stop halts the routing logic.
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`default_nettype none
module evr_top #(
  parameter int NUM_DST = evr_pkg::NUM_DST,
  parameter int SRC_W = evr_pkg::SRC_W
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [11:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [11:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [SRC_W-1:0] i_src_events,
  output logic [NUM_DST-1:0] o_dst_events,
  output logic [2:0] o_timer_start,
  output logic [2:0] o_timer_restart,
  output logic [2:0] o_timer_count,
  input wire logic [7:0] i_port_b_pins,
  input wire logic [7:0] i_port_e_pins,
  output logic [7:0] o_port_b_out,
  output logic [7:0] o_port_e_out,
  output logic o_module_stopped
);
  typedef struct packed {
    logic [NUM_DST-1:0][7:0] link;
    logic [7:0] opt_a;
    logic [7:0] opt_d;
    logic [7:0] opt_f;
    logic [7:0] opt_h;
    logic stop;
    logic [evr_pkg::PCFG_W-1:0] pcfg_b;
    logic [evr_pkg::PCFG_W-1:0] pcfg_e;
    logic [NUM_DST-1:0] dst;
    logic [2:0] tstart;
    logic [2:0] trestart;
    logic [2:0] tcount;
    logic [15:0] evt_cnt;
  } evr_top_t;

  evr_top_t s_reg;
  evr_top_t s_next;
  evr_reg_if reg_bus ();
  logic pb_evt;
  logic pe_evt;

  // out-of-range selects route nothing instead of aliasing another source
  function automatic logic route_sel(input logic [7:0] sel, input logic [SRC_W-1:0] src);
    logic hit;
    hit = 1'b0;
    if (sel >= evr_pkg::SEL_MIN && sel <= evr_pkg::SEL_MAX) begin
      hit = src[sel];
    end
    return hit;
  endfunction

  // returns {count, restart, start}
  function automatic logic [2:0] timer_act(input logic [1:0] op, input logic evt);
    logic [2:0] act;
    act = 3'b000;
    if (evt) begin
      case (op)
        evr_pkg::OP_START: act = 3'b001;
        evr_pkg::OP_RESTART: act = 3'b010;
        evr_pkg::OP_COUNT: act = 3'b100;
        default: act = 3'b000;
      endcase
    end
    return act;
  endfunction

  function automatic logic [7:0] put_byte(input logic [7:0] old, input logic [7:0] data,
                                          input logic en);
    return en ? data : old;
  endfunction

  function automatic logic link_addr(input logic [11:0] addr);
    return addr < evr_pkg::LINK_END && evr_pkg::DST_IMPL[addr[7:2]];
  endfunction

  evr_axil_slave u_axil (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid),
    .o_awready(o_awready),
    .i_wdata(i_wdata),
    .i_wstrb(i_wstrb),
    .i_wvalid(i_wvalid),
    .o_wready(o_wready),
    .o_bresp(o_bresp),
    .o_bvalid(o_bvalid),
    .i_bready(i_bready),
    .i_araddr(i_araddr),
    .i_arvalid(i_arvalid),
    .o_arready(o_arready),
    .o_rdata(o_rdata),
    .o_rresp(o_rresp),
    .o_rvalid(o_rvalid),
    .i_rready(i_rready),
    .reg_bus(reg_bus.bus)
  );

  evr_port_event u_port_b (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_stop(s_reg.stop),
    .i_cfg(s_reg.pcfg_b),
    .i_pins(i_port_b_pins),
    .i_dst_evt(s_reg.dst[evr_pkg::DST_PORT_B]),
    .o_src_evt(pb_evt),
    .o_out(o_port_b_out)
  );

  evr_port_event u_port_e (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_stop(s_reg.stop),
    .i_cfg(s_reg.pcfg_e),
    .i_pins(i_port_e_pins),
    .i_dst_evt(s_reg.dst[evr_pkg::DST_PORT_E]),
    .o_src_evt(pe_evt),
    .o_out(o_port_e_out)
  );

  always_comb begin
    logic [SRC_W-1:0] src_all;
    logic [11:0] wa;
    logic [2:0] act0;
    logic [2:0] act1;
    logic [2:0] act3;
    src_all = i_src_events;
    src_all[evr_pkg::EVT_PORT_B] = i_src_events[evr_pkg::EVT_PORT_B] | pb_evt;
    src_all[evr_pkg::EVT_PORT_E] = i_src_events[evr_pkg::EVT_PORT_E] | pe_evt;
    wa = {reg_bus.wr_addr[11:2], 2'b00};
    s_next = s_reg;
    reg_bus.wr_err = 1'b0;

    for (int d = 0; d < NUM_DST; d++) begin
      // no register, no route: unlisted destinations stay silent
      s_next.dst[d] = evr_pkg::DST_IMPL[d] && !s_reg.stop
                      && route_sel(s_reg.link[d], src_all);
    end
    if (s_reg.stop) begin
      s_next.dst = '0;
    end

    act0 = timer_act(s_reg.opt_a[evr_pkg::OPA_MULTI_TIMER_CHANNEL0_LSB +: 2], s_next.dst[evr_pkg::DST_MULTI_TIMER_CHANNEL0]);
    act1 = timer_act(s_reg.opt_d[evr_pkg::OPD_BYTE_TIMER_CHANNEL1_LSB +: 2], s_next.dst[evr_pkg::DST_BYTE_TIMER_CHANNEL1]);
    act3 = timer_act(s_reg.opt_d[evr_pkg::OPD_BYTE_TIMER_CHANNEL3_LSB +: 2], s_next.dst[evr_pkg::DST_BYTE_TIMER_CHANNEL3]);
    s_next.tstart = {act3[0], act1[0], act0[0]};
    s_next.trestart = {act3[1], act1[1], act0[1]};
    s_next.tcount = {act3[2], act1[2], act0[2]};
    if (|s_next.dst) begin
      s_next.evt_cnt = s_reg.evt_cnt + 16'h0001;
    end

    if (reg_bus.wr_en) begin
      if (link_addr(wa)) begin
        // firmware must keep to 00h or 01h..BDh; others route nothing here
        s_next.link[wa[7:2]] = put_byte(s_reg.link[wa[7:2]], reg_bus.wr_data[7:0],
                                        reg_bus.wr_strb[0]);
      end else begin
        case (wa)
          evr_pkg::OPT_A_ADDR: s_next.opt_a = put_byte(s_reg.opt_a, reg_bus.wr_data[7:0],
                                                      reg_bus.wr_strb[0]);
          evr_pkg::OPT_D_ADDR: s_next.opt_d = put_byte(s_reg.opt_d, reg_bus.wr_data[7:0],
                                                      reg_bus.wr_strb[0]);
          evr_pkg::OPT_F_ADDR: s_next.opt_f = put_byte(s_reg.opt_f, reg_bus.wr_data[7:0],
                                                      reg_bus.wr_strb[0]);
          evr_pkg::OPT_H_ADDR: s_next.opt_h = put_byte(s_reg.opt_h, reg_bus.wr_data[7:0],
                                                      reg_bus.wr_strb[0]);
          evr_pkg::CTRL_ADDR: begin
            if (reg_bus.wr_strb[0]) begin
              s_next.stop = reg_bus.wr_data[evr_pkg::CTRL_STOP_BIT];
            end
          end
          evr_pkg::PCFG_B_ADDR: begin
            s_next.pcfg_b[7:0] = put_byte(s_reg.pcfg_b[7:0], reg_bus.wr_data[7:0],
                                          reg_bus.wr_strb[0]);
            if (reg_bus.wr_strb[1]) begin
              s_next.pcfg_b[11:8] = reg_bus.wr_data[11:8];
            end
          end
          evr_pkg::PCFG_E_ADDR: begin
            s_next.pcfg_e[7:0] = put_byte(s_reg.pcfg_e[7:0], reg_bus.wr_data[7:0],
                                          reg_bus.wr_strb[0]);
            if (reg_bus.wr_strb[1]) begin
              s_next.pcfg_e[11:8] = reg_bus.wr_data[11:8];
            end
          end
          default: reg_bus.wr_err = 1'b1;
        endcase
      end
    end
  end

  always_comb begin
    logic [11:0] ra;
    ra = {reg_bus.rd_addr[11:2], 2'b00};
    reg_bus.rd_data = 32'h0000_0000;
    reg_bus.rd_err = 1'b0;
    if (link_addr(ra)) begin
      reg_bus.rd_data[7:0] = s_reg.link[ra[7:2]];
    end else begin
      case (ra)
        evr_pkg::OPT_A_ADDR: reg_bus.rd_data[7:0] = s_reg.opt_a;
        evr_pkg::OPT_D_ADDR: reg_bus.rd_data[7:0] = s_reg.opt_d;
        evr_pkg::OPT_F_ADDR: reg_bus.rd_data[7:0] = s_reg.opt_f;
        evr_pkg::OPT_H_ADDR: reg_bus.rd_data[7:0] = s_reg.opt_h;
        evr_pkg::CTRL_ADDR: reg_bus.rd_data[evr_pkg::CTRL_STOP_BIT] = s_reg.stop;
        evr_pkg::PCFG_B_ADDR: reg_bus.rd_data[11:0] = s_reg.pcfg_b;
        evr_pkg::PCFG_E_ADDR: reg_bus.rd_data[11:0] = s_reg.pcfg_e;
        evr_pkg::STATUS_ADDR: begin
          reg_bus.rd_data[15:0] = s_reg.evt_cnt;
          reg_bus.rd_data[evr_pkg::STATUS_STOP_BIT] = s_reg.stop;
        end
        default: reg_bus.rd_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_dst_events = s_reg.dst;
  assign o_timer_start = s_reg.tstart;
  assign o_timer_restart = s_reg.trestart;
  assign o_timer_count = s_reg.tcount;
  assign o_module_stopped = s_reg.stop;
endmodule // evr_top
`default_nettype wire

// >>> verif/evr_chk.sv
`default_nettype none
module evr_chk #(
  parameter int NUM_DST = evr_pkg::NUM_DST,
  parameter int SRC_W = evr_pkg::SRC_W
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic [SRC_W-1:0] i_src_events,
  input wire logic [NUM_DST-1:0] o_dst_events,
  input wire logic [2:0] o_timer_start,
  input wire logic [2:0] o_timer_restart,
  input wire logic [2:0] o_timer_count,
  input wire logic [7:0] i_port_b_pins,
  input wire logic [7:0] i_port_e_pins,
  input wire logic o_module_stopped
);
  logic [7:0] pb_reg;
  logic [7:0] pe_reg;
  logic [2:0] quiet_reg;
  // pin edges raise events with no source bit, so only quiet spells are judged
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pb_reg <= 8'h00;
      pe_reg <= 8'h00;
      quiet_reg <= 3'h0;
    end else begin
      pb_reg <= i_port_b_pins;
      pe_reg <= i_port_e_pins;
      if (pb_reg != i_port_b_pins || pe_reg != i_port_e_pins) begin
        quiet_reg <= 3'h0;
      end else if (quiet_reg != 3'h7) begin
        quiet_reg <= quiet_reg + 3'h1;
      end
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_b_late;
    !o_bvalid ##1 o_bvalid;
  endsequence
  a_wr_answer: assert property (s_wr_taken |=> s_b_late)
    else $error("write response not two cycles after handshake");
  a_b_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped before taken");
  a_rd_answer: assert property (i_arvalid && o_arready |=> !o_rvalid ##1 o_rvalid)
    else $error("read data late");
  a_unimpl_quiet: assert property ((o_dst_events & ~evr_pkg::DST_IMPL) == '0)
    else $error("pulse on destination without link register");
  a_stop_silent: assert property (o_module_stopped |=> o_dst_events == '0)
    else $error("event delivered while stopped");
  a_stop_by_write: assert property ($changed(o_module_stopped) |-> o_bvalid)
    else $error("stop state moved without a write");
  a_timer_follows: assert property (((o_timer_start | o_timer_restart | o_timer_count)
    & ~{o_dst_events[18], o_dst_events[16], o_dst_events[4]}) == 3'h0)
    else $error("timer action without its destination pulse");
  a_timer_onehot: assert property ((o_timer_start & o_timer_restart) == 3'h0
    && ((o_timer_start | o_timer_restart) & o_timer_count) == 3'h0)
    else $error("two timer actions at once");
  a_event_cause: assert property (|o_dst_events && quiet_reg > 3'h3
    |-> $past(|i_src_events))
    else $error("destination pulse without source event");
endmodule // evr_chk
bind evr_top evr_chk #(.NUM_DST(NUM_DST), .SRC_W(SRC_W)) u_chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_awvalid(i_awvalid), .o_awready(o_awready),
  .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
  .i_bready(i_bready), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid),
  .i_src_events(i_src_events), .o_dst_events(o_dst_events), .o_timer_start(o_timer_start),
  .o_timer_restart(o_timer_restart), .o_timer_count(o_timer_count),
  .i_port_b_pins(i_port_b_pins), .i_port_e_pins(i_port_e_pins),
  .o_module_stopped(o_module_stopped)
);
`default_nettype wire

// >>> verif/evr_evt_src.sv
`default_nettype none
module evr_evt_src #(
  parameter int SRC_W = 190
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_fire,
  input wire logic [7:0] i_num,
  output logic [SRC_W-1:0] o_src_events
);
  timeunit 1ns;
  timeprecision 1ps;
  // producers give one-cycle pulses; numbers past the top never pulse
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_src_events <= '0;
    end else begin
      o_src_events <= '0;
      if (i_fire && int'(i_num) < SRC_W) o_src_events[i_num] <= 1'b1;
    end
  end
endmodule // evr_evt_src
`default_nettype wire

// >>> verif/tb.sv
`default_nettype none
`define CHK(nm, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("unexpected %s exp %h got %h", nm, e, g); \
  end \
end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [11:0] i_awaddr = 12'h000;
  logic [11:0] i_araddr = 12'h000;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic [3:0] i_wstrb = 4'h0;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic [7:0] pins_b = 8'h00, pins_e = 8'h00, ev_num = 8'h00;
  logic ev_fire = 1'b0;
  logic [evr_pkg::SRC_W-1:0] src;
  logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, stopped;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [45:0] dst;
  logic [2:0] t_st, t_rs, t_ct;
  logic [7:0] out_b, out_e;
  logic [63:0] rd_q[$], wr_q[$], ev_q[$];
  int checks_done = 0;
  int miscompares = 0;
  always #12.5 i_clk = ~i_clk;
  evr_evt_src u_src (.i_clk(i_clk), .i_resetn(i_resetn), .i_fire(ev_fire), .i_num(ev_num),
    .o_src_events(src));
  evr_top dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
    .o_awready(aw_rdy), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
    .o_wready(w_rdy), .o_bresp(bresp), .o_bvalid(b_vld), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(ar_rdy), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(r_vld), .i_rready(i_rready), .i_src_events(src),
    .o_dst_events(dst), .o_timer_start(t_st), .o_timer_restart(t_rs), .o_timer_count(t_ct),
    .i_port_b_pins(pins_b), .i_port_e_pins(pins_e), .o_port_b_out(out_b),
    .o_port_e_out(out_e), .o_module_stopped(stopped));
  task automatic final_report;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic take(ref logic [63:0] q[$], input logic [63:0] g, input string nm);
    logic [63:0] e;
    e = 64'hffff_ffff_ffff_ffff;
    if (q.size() > 0) e = q.pop_front();
    `CHK(nm, e, g)
  endtask
  always @(posedge i_clk) begin
    if (i_resetn === 1'b1 && b_vld === 1'b1 && i_bready === 1'b1) take(wr_q, 64'(bresp), "bresp");
    if (i_resetn === 1'b1 && r_vld === 1'b1 && i_rready === 1'b1) begin
      take(rd_q, 64'({rresp, rdata}), "read");
    end
    if (i_resetn === 1'b1 && {t_st, t_rs, t_ct, dst} !== 55'h0) begin
      take(ev_q, 64'({t_st, t_rs, t_ct, dst}), "events");
    end
  end
  function automatic logic [63:0] ev_exp(input int d, input logic [1:0] op);
    logic [63:0] v;
    int t;
    v = 64'h0;
    v[d] = 1'b1;
    t = d == evr_pkg::DST_MULTI_TIMER_CHANNEL0 ? 0 : d == evr_pkg::DST_BYTE_TIMER_CHANNEL1 ? 1 : -1;
    if (d == evr_pkg::DST_BYTE_TIMER_CHANNEL3) t = 2;
    if (t >= 0 && op != evr_pkg::OP_NONE) v[46 + 3 * (2 - int'(op)) + t] = 1'b1;
    return v;
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge i_clk);
    wr_q.push_back(64'(er));
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= {2'($urandom), 2'h3};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (aw_rdy === 1'b1) i_awvalid <= 1'b0;
      if (w_rdy === 1'b1) i_wvalid <= 1'b0;
    end while (!(b_vld === 1'b1 && i_bready === 1'b1));
    i_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [63:0] e);
    @(posedge i_clk);
    rd_q.push_back(e);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (ar_rdy === 1'b1) i_arvalid <= 1'b0;
    end while (r_vld !== 1'b1);
    i_rready <= 1'b0;
  endtask
  task automatic fire(input logic [7:0] n);
    @(posedge i_clk);
    ev_fire <= 1'b1;
    ev_num <= n;
    @(posedge i_clk);
    ev_fire <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
  initial begin
    logic [7:0] sel;
    logic [11:0] a;
    logic [1:0] r, o;
    logic imp;
    logic [63:0] e;
    int tmr[3] = '{evr_pkg::DST_MULTI_TIMER_CHANNEL0, evr_pkg::DST_BYTE_TIMER_CHANNEL1, evr_pkg::DST_BYTE_TIMER_CHANNEL3};
    void'($urandom(32'h0000_79be));
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    for (int d = 0; d < 46; d++) begin
      imp = d inside {0, 3, 4, 7, [10:13], 15, 16, [18:28], 33, [35:38], 45};
      r = imp ? evr_pkg::RESP_OKAY : evr_pkg::RESP_SLVERR;
      sel = d == 0 ? 8'h01 : d == 45 ? 8'hbd : 8'(1 + $urandom_range(186));
      a = 12'(4 * d);
      rd(a, {30'h0, r, 32'h0});
      wr(a, {24'h0, sel}, r);
      rd(a, {30'h0, r, 24'h0, imp ? sel : 8'h00});
      if (imp) ev_q.push_back(ev_exp(d, evr_pkg::OP_START));
      fire(sel);
      wr(a, 32'h0, r);
      fire(sel);
    end
    wr(12'h000, 32'h0000_00be, evr_pkg::RESP_OKAY);
    rd(12'h000, {30'h0, evr_pkg::RESP_OKAY, 32'h0000_00be});
    foreach (tmr[i]) wr(12'(4 * tmr[i]), 32'h0000_0007, evr_pkg::RESP_OKAY);
    for (int op = 0; op < 4; op++) begin
      o = 2'(op);
      wr(evr_pkg::OPT_A_ADDR, {28'h0, ~o, o}, evr_pkg::RESP_OKAY);
      wr(evr_pkg::OPT_D_ADDR, {24'h0, o, ~o, o, ~o}, evr_pkg::RESP_OKAY);
      rd(evr_pkg::OPT_A_ADDR, {30'h0, evr_pkg::RESP_OKAY, 28'h0, ~o, o});
      e = 64'h0;
      foreach (tmr[i]) e |= ev_exp(tmr[i], o);
      ev_q.push_back(e);
      fire(8'h07);
    end
    wr(evr_pkg::CTRL_ADDR, 32'h0000_0001, evr_pkg::RESP_OKAY);
    `CHK("stopped", 1'b1, stopped)
    fire(8'h07);
    wr(evr_pkg::CTRL_ADDR, 32'h0000_0000, evr_pkg::RESP_OKAY);
    ev_q.push_back(e);
    fire(8'h07);
    // bit 3 alone on port b, group of bits 7:4 on port e
    wr(evr_pkg::PCFG_B_ADDR, 32'h0000_0300, evr_pkg::RESP_OKAY);
    wr(evr_pkg::PCFG_E_ADDR, 32'h0000_08f0, evr_pkg::RESP_OKAY);
    wr(12'h000, 32'h0000_00bc, evr_pkg::RESP_OKAY);
    wr(12'h00c, 32'h0000_00bd, evr_pkg::RESP_OKAY);
    pins_b <= 8'h01;
    pins_e <= 8'h02;
    repeat (6) @(posedge i_clk);
    ev_q.push_back(ev_exp(0, 2'h0) | ev_exp(3, 2'h0));
    pins_b <= 8'h09;
    pins_e <= 8'h22;
    repeat (6) @(posedge i_clk);
    wr(12'(4 * evr_pkg::DST_PORT_B), 32'h0000_0009, evr_pkg::RESP_OKAY);
    wr(12'(4 * evr_pkg::DST_PORT_E), 32'h0000_0009, evr_pkg::RESP_OKAY);
    ev_q.push_back(ev_exp(36, 2'h0) | ev_exp(37, 2'h0));
    fire(8'h09);
    // bit 0 was already toggled once by the sweep, when both configs were still reset
    `CHK("port b out", 8'h09, out_b)
    `CHK("port e out", 8'hf1, out_e)
    wr(12'h200, 32'h0000_0001, evr_pkg::RESP_SLVERR);
    rd(12'h200, {30'h0, evr_pkg::RESP_SLVERR, 32'h0});
    repeat (4) @(posedge i_clk);
    `CHK("pending", 0, rd_q.size() + wr_q.size() + ev_q.size())
    final_report();
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    final_report();
  end
endmodule // tb
`default_nettype wire
